// >>> verilog/pms_defines.svh
// What this block does
// R1 - bit 7 set: second serial unit clock stopped, unit held in standby
// R2 - bit 4 set: type-B timer unit held in standby, clock stopped
// R3 - bit 1 set: type-Z timer unit held in standby, clock stopped
// R4 - bit 0 set: pwm unit held in standby, clock stopped
// R5 - bits 6,5,3,2 read zero, writes ignored
// R6 - sleep instruction moves execution state to halt state unless direct transition
// R7 - accepted interrupt returns any halt state to an execution state
// R8 - direct transition between active and subactive without halting
// R9 - active-to-active and subactive-to-subactive direct transitions allowed
// R10 - external reset input forces reset state from any state
// R11 - all selects zero: sleep; wake to active or subactive by low-speed bit
// R12 - subsleep select set: subsleep; wake target by low-speed bit
// R13 - software standby select set: standby; interrupt wakes to active
// R14 - direct select set: go to active or subactive by low-speed bit
// R15 - transition with subsleep select set resets timer V, serials, converter
// R16 - software reprograms those peripherals after such a transition
// R17 - watchdog holds in low-power states unless clocked by internal oscillator; code holds it in subactive, subsleep, standby, settle, not sleep
// R18 - no wakeup while cpu mask set or source interrupt disabled
// R19 - leaving standby waits the programmed oscillator settling time first
// R20 - direct transition with its interrupt disabled enters sleep or subsleep; the code enters standby instead when the standby select is set
// R21 - standby puts port outputs in high impedance, registers kept
// R22 - mode bits sampled at sleep; target held until wakeup or reset
// R23 - clearing a standby bit restores the unit clock, contents untouched
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH
`define PMS_ADDR_GATE_B 12'h000
`define PMS_ADDR_MODE 12'h004
`define PMS_ADDR_STATE 12'h008
`define PMS_GATE_MASK 8'h93
`define PMS_BIT_SERIAL_B 7
`define PMS_BIT_TIMER_B 4
`define PMS_BIT_TIMER_Z 1
`define PMS_BIT_PWM 0
`define PMS_MODE_DT 0
`define PMS_MODE_SOFTWARE_STANDBY_SELECT 1
`define PMS_MODE_SUB 2
`define PMS_MODE_LS 3
`define PMS_MODE_WAIT_LSB 4
`define PMS_WAIT_UNIT 16'h0100
`endif

// >>> verilog/pms_pkg.sv
package pms_pkg;
   typedef enum logic [6:0] {
      PMS_RESET = 7'h01,
      PMS_ACTIVE = 7'h02,
      PMS_SUBACTIVE = 7'h04,
      PMS_SLEEP = 7'h08,
      PMS_SUBSLEEP = 7'h10,
      PMS_STANDBY = 7'h20,
      PMS_SETTLE = 7'h40
   } pms_state_t;
endpackage

// >>> verilog/pms_power_mode_sequencer.sv
`timescale 1ns/1ps
`include "pms_defines.svh"
module pms_power_mode_sequencer (
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   // apb slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // cpu side
   input wire logic I_SLEEP_EXEC,
   input wire logic I_IRQ_PENDING,
   input wire logic I_IRQ_ENABLED,
   input wire logic I_CPU_MASK,
   input wire logic I_DT_IRQ_ENABLED,
   input wire logic I_EXTERNAL_RESET_INPUT_N,
   input wire logic I_WDT_INT_OSC,
   // peripheral controls
   output logic O_SERIAL_UNIT_B_SLEEP,
   output logic O_TIMER_B_UNIT_SLEEP,
   output logic O_TIMER_Z_UNIT_SLEEP,
   output logic O_PWM_UNIT_SLEEP,
   output logic O_SUBSLEEP_PERIPH_RESET,
   output logic O_WDT_HOLD,
   output logic O_PORT_HIZ,
   output logic O_CPU_RUN,
   output logic O_LOW_SPEED,
   output logic O_WAKE_IRQ,
   output pms_pkg::pms_state_t O_STATE
);
   import pms_pkg::*;

   // ----------------------------------------
   // register bus
   // ----------------------------------------
   logic [7:0] gate_reg;
   logic [7:0] gate_next;
   logic [6:0] mode_reg;
   logic [6:0] mode_next;
   logic [6:0] tgt_reg;
   logic [6:0] tgt_next;
   pms_state_t state_reg;
   pms_state_t state_next;
   logic [18:0] wait_reg;
   logic [18:0] wait_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic rst_pulse_reg;
   logic rst_pulse_next;

   wire acc = I_PSEL & I_PENABLE;
   wire hit_gate = (I_PADDR == `PMS_ADDR_GATE_B);
   wire hit_mode = (I_PADDR == `PMS_ADDR_MODE);
   wire hit_state = (I_PADDR == `PMS_ADDR_STATE);
   wire hit_any = hit_gate | hit_mode | hit_state;
   wire wr_gate = acc & I_PWRITE & hit_gate;
   wire wr_mode = acc & I_PWRITE & hit_mode;
   wire rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;

   assign O_PREADY = 1'b1;
   assign O_PSLVERR = acc & ~hit_any;
   assign O_PRDATA = rdata_reg;

   // reserved bits are masked on write so they always read zero
   assign gate_next = wr_gate ? (I_PWDATA[7:0] & `PMS_GATE_MASK) : gate_reg; // [R5]
   assign mode_next = wr_mode ? I_PWDATA[6:0] : mode_reg;
   // read data is loaded in the setup cycle so it already stands when the access phase completes
   assign rdata_next = (rd_setup & hit_gate) ? {24'h000000, gate_reg} :
      (rd_setup & hit_mode) ? {25'h0000000, mode_reg} :
      (rd_setup & hit_state) ? {25'h0000000, state_reg} : rdata_reg;

   // ----------------------------------------
   // mode selection
   // ----------------------------------------
   wire m_dt = mode_reg[`PMS_MODE_DT];
   wire m_software_standby_select = mode_reg[`PMS_MODE_SOFTWARE_STANDBY_SELECT];
   wire m_sub = mode_reg[`PMS_MODE_SUB];
   wire m_ls = mode_reg[`PMS_MODE_LS];
   wire [2:0] m_wait = mode_reg[`PMS_MODE_WAIT_LSB +: 3];
   wire running = (state_reg == PMS_ACTIVE) | (state_reg == PMS_SUBACTIVE);
   wire halted = (state_reg == PMS_SLEEP) | (state_reg == PMS_SUBSLEEP) | (state_reg == PMS_STANDBY);
   wire sleep_go = running & I_SLEEP_EXEC;
   wire wake_ok = I_IRQ_PENDING & I_IRQ_ENABLED & ~I_CPU_MASK; // [R18]
   wire direct = m_dt & I_DT_IRQ_ENABLED; // [R20]
   wire [6:0] run_tgt = m_ls ? PMS_SUBACTIVE : PMS_ACTIVE;

   // direct targets are evaluated before halt targets; active->active allowed
   assign state_next = ~I_EXTERNAL_RESET_INPUT_N ? PMS_RESET : // [R10]
      (state_reg == PMS_RESET) ? PMS_ACTIVE :
      (sleep_go & direct) ? pms_state_t'(run_tgt) : // [R8] [R9] [R14]
      (sleep_go & m_software_standby_select) ? PMS_STANDBY : // [R13]
      (sleep_go & m_sub) ? PMS_SUBSLEEP : // [R12]
      sleep_go ? PMS_SLEEP : // [R6] [R11]
      ((state_reg == PMS_STANDBY) & wake_ok) ? PMS_SETTLE : // [R19]
      (((state_reg == PMS_SLEEP) | (state_reg == PMS_SUBSLEEP)) & wake_ok) ? pms_state_t'(tgt_reg) : // [R7]
      ((state_reg == PMS_SETTLE) & (wait_reg == 19'h00000)) ? pms_state_t'(tgt_reg) :
      state_reg;

   // target latched at the sleep instruction and held until wakeup [R22]
   assign tgt_next = sleep_go ? ((m_software_standby_select & ~direct) ? PMS_ACTIVE : run_tgt) : tgt_reg;
   assign wait_next = ((state_reg == PMS_STANDBY) & wake_ok) ? 19'((m_wait + 19'h1) * `PMS_WAIT_UNIT) :
      (wait_reg != 19'h00000) ? wait_reg - 19'h1 : wait_reg;
   assign rst_pulse_next = sleep_go & m_sub; // [R15]

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         gate_reg <= 8'h00;
         mode_reg <= 7'h00;
         tgt_reg <= PMS_ACTIVE;
         state_reg <= PMS_RESET;
         wait_reg <= 19'h00000;
         rdata_reg <= 32'h00000000;
         rst_pulse_reg <= 1'b0;
      end else begin
         gate_reg <= gate_next;
         mode_reg <= mode_next;
         tgt_reg <= tgt_next;
         state_reg <= state_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         rst_pulse_reg <= rst_pulse_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // gate outputs follow the bit directly, so clearing restores the clock [R23]
   assign O_SERIAL_UNIT_B_SLEEP = gate_reg[`PMS_BIT_SERIAL_B]; // [R1]
   assign O_TIMER_B_UNIT_SLEEP = gate_reg[`PMS_BIT_TIMER_B]; // [R2]
   assign O_TIMER_Z_UNIT_SLEEP = gate_reg[`PMS_BIT_TIMER_Z]; // [R3]
   assign O_PWM_UNIT_SLEEP = gate_reg[`PMS_BIT_PWM]; // [R4]
   assign O_SUBSLEEP_PERIPH_RESET = rst_pulse_reg;
   assign O_WDT_HOLD = ~I_WDT_INT_OSC & ((state_reg == PMS_SUBACTIVE) | (state_reg == PMS_SUBSLEEP) |
      (state_reg == PMS_STANDBY) | (state_reg == PMS_SETTLE)); // [R17]
   assign O_PORT_HIZ = (state_reg == PMS_STANDBY) | (state_reg == PMS_SETTLE); // [R21]
   assign O_CPU_RUN = running;
   assign O_LOW_SPEED = (state_reg == PMS_SUBACTIVE) | (state_reg == PMS_SUBSLEEP);
   assign O_WAKE_IRQ = halted & wake_ok;
   assign O_STATE = state_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);

   // external reset outranks everything, so most checks only look while it is released
   wire go_ok = sleep_go & I_EXTERNAL_RESET_INPUT_N;
   wire wake_go = wake_ok & I_EXTERNAL_RESET_INPUT_N;
   wire sleepish = (state_reg == PMS_SLEEP) | (state_reg == PMS_SUBSLEEP);

   // ----------------------------------------
   // register checks
   // ----------------------------------------
   a_gate_serial_b: assert property (wr_gate |=> O_SERIAL_UNIT_B_SLEEP == $past(I_PWDATA[7])) // [R1]
      else $error("serial gate wrong");

   a_gate_timer_b: assert property (wr_gate |=> O_TIMER_B_UNIT_SLEEP == $past(I_PWDATA[4])) // [R2]
      else $error("timer b gate wrong");

   a_gate_timer_z: assert property (wr_gate |=> O_TIMER_Z_UNIT_SLEEP == $past(I_PWDATA[1])) // [R3]
      else $error("timer z gate wrong");

   a_gate_pwm: assert property (wr_gate |=> O_PWM_UNIT_SLEEP == $past(I_PWDATA[0])) // [R4]
      else $error("pwm gate wrong");

   a_reserved_zero: assert property (wr_gate |=> (gate_reg[6:5] == 2'b00) && (gate_reg[3:2] == 2'b00)) // [R5]
      else $error("reserved bit set");

   a_gate_write: assert property (wr_gate |=> gate_reg[4] == $past(I_PWDATA[4]) && gate_reg[1:0] == $past(I_PWDATA[1:0])) // [R2]
      else $error("gate write lost");

   a_gate_held: assert property (!wr_gate |=> $stable(gate_reg)) // [R23]
      else $error("gate changed without write");

   a_gate_clear: assert property (wr_gate && !I_PWDATA[7] |=> !O_SERIAL_UNIT_B_SLEEP) // [R23]
      else $error("cleared gate still stopped");

   a_read_gate: assert property (rd_setup && hit_gate |=> O_PRDATA == {24'h000000, $past(gate_reg)}) // [R5]
      else $error("gate read wrong");

   a_read_hold: assert property (!rd_setup |=> $stable(O_PRDATA))
      else $error("read data moved");

   a_mode_write: assert property (wr_mode |=> mode_reg == $past(I_PWDATA[6:0])) // [R22]
      else $error("mode write lost");

   a_bad_addr: assert property (acc && !hit_any |-> O_PSLVERR)
      else $error("unmapped access accepted");

   a_err_quiet: assert property (!acc |-> !O_PSLVERR)
      else $error("error outside access");

   // ----------------------------------------
   // sleep instruction checks
   // ----------------------------------------
   a_sleep_halts: assert property (go_ok && !direct |=> halted) // [R6]
      else $error("sleep did not halt");

   a_sleep_plain: assert property (go_ok && !direct && !m_software_standby_select && !m_sub |=> state_reg == PMS_SLEEP) // [R11]
      else $error("sleep not entered");

   a_sleep_sub: assert property (go_ok && !direct && !m_software_standby_select && m_sub |=> state_reg == PMS_SUBSLEEP) // [R12]
      else $error("subsleep not entered");

   a_sleep_standby: assert property (go_ok && !direct && m_software_standby_select |=> state_reg == PMS_STANDBY) // [R13]
      else $error("standby not entered");

   a_direct_runs: assert property (go_ok && direct |=> O_LOW_SPEED == $past(m_ls) && running) // [R14]
      else $error("direct transition wrong");

   a_direct_same: assert property (go_ok && direct && state_reg == PMS_ACTIVE && !m_ls |=> state_reg == PMS_ACTIVE) // [R9]
      else $error("active to active failed");

   a_direct_switch: assert property (go_ok && direct && state_reg == PMS_ACTIVE && m_ls |=> state_reg == PMS_SUBACTIVE) // [R8]
      else $error("active to subactive failed");

   a_direct_blocked: assert property (go_ok && m_dt && !I_DT_IRQ_ENABLED |=> halted) // [R20]
      else $error("blocked direct did not halt");

   a_target_pick: assert property (sleep_go && !m_software_standby_select |=> tgt_reg == ($past(m_ls) ? PMS_SUBACTIVE : PMS_ACTIVE)) // [R22]
      else $error("wake target wrong");

   a_target_held: assert property (halted && !wake_ok |=> $stable(tgt_reg)) // [R22]
      else $error("wake target lost");

   a_halt_no_run: assert property (halted |-> !O_CPU_RUN) // [R6]
      else $error("cpu runs while halted");

   // ----------------------------------------
   // wakeup checks
   // ----------------------------------------
   a_wake_sleep: assert property (sleepish && wake_go |=> state_reg == $past(tgt_reg)) // [R7]
      else $error("sleep wake wrong");

   a_wake_ls: assert property (sleepish && wake_go && tgt_reg == PMS_SUBACTIVE |=> O_LOW_SPEED && O_CPU_RUN) // [R11]
      else $error("low speed wake wrong");

   a_standby_wake: assert property (state_reg == PMS_STANDBY && wake_go |=> state_reg == PMS_SETTLE) // [R19]
      else $error("standby wake wrong");

   a_standby_target: assert property (state_reg == PMS_STANDBY |-> tgt_reg == PMS_ACTIVE) // [R13]
      else $error("standby target wrong");

   a_settle_hold: assert property (state_reg == PMS_SETTLE && wait_reg != 19'h00000 && I_EXTERNAL_RESET_INPUT_N
      |=> state_reg == PMS_SETTLE) // [R19]
      else $error("settle cut short");

   a_settle_done: assert property (state_reg == PMS_SETTLE && wait_reg == 19'h00000 && I_EXTERNAL_RESET_INPUT_N
      |=> state_reg == PMS_ACTIVE) // [R19]
      else $error("settle did not end");

   a_mask_blocks: assert property (halted && I_CPU_MASK && I_EXTERNAL_RESET_INPUT_N |=> halted) // [R18]
      else $error("masked wakeup");

   a_disabled_blocks: assert property (halted && !I_IRQ_ENABLED && I_EXTERNAL_RESET_INPUT_N |=> halted) // [R18]
      else $error("disabled source woke");

   a_standby_stay: assert property (state_reg == PMS_STANDBY && !wake_go && I_EXTERNAL_RESET_INPUT_N
      |=> state_reg == PMS_STANDBY) // [R18]
      else $error("standby left without wake");

   // ----------------------------------------
   // reset and output checks
   // ----------------------------------------
   a_reset_wins: assert property (!I_EXTERNAL_RESET_INPUT_N |=> state_reg == PMS_RESET) // [R10]
      else $error("reset not entered");

   a_reset_leaves: assert property (state_reg == PMS_RESET && I_EXTERNAL_RESET_INPUT_N |=> state_reg == PMS_ACTIVE) // [R10]
      else $error("reset not left");

   a_sub_reset: assert property (sleep_go && m_sub |=> O_SUBSLEEP_PERIPH_RESET) // [R15]
      else $error("periph reset missing");

   a_sub_pulse_only: assert property (O_SUBSLEEP_PERIPH_RESET |-> $past(sleep_go && m_sub)) // [R15]
      else $error("stray periph reset");

   a_wdt_hold: assert property ((state_reg == PMS_SUBACTIVE || state_reg == PMS_SUBSLEEP || state_reg == PMS_STANDBY)
      && !I_WDT_INT_OSC |-> O_WDT_HOLD) // [R17]
      else $error("watchdog not held");

   a_wdt_free: assert property (I_WDT_INT_OSC |-> !O_WDT_HOLD) // [R17]
      else $error("watchdog held on internal clock");

   a_standby_hiz: assert property (state_reg == PMS_STANDBY |-> O_PORT_HIZ && !O_CPU_RUN) // [R21]
      else $error("standby ports driven");

   a_settle_ports: assert property (state_reg == PMS_SETTLE |-> O_PORT_HIZ) // [R21]
      else $error("settle ports driven");

   a_run_ports: assert property (running |-> !O_PORT_HIZ) // [R21]
      else $error("ports released while running");

   a_sub_low: assert property (state_reg == PMS_SUBACTIVE |-> O_LOW_SPEED && O_CPU_RUN) // [R8]
      else $error("subactive outputs wrong");

   a_state_onehot: assert property ($onehot(state_reg))
      else $error("state not one-hot");

   c_sleep_wake: cover property (state_reg == PMS_SLEEP ##1 running);
   c_standby_settle: cover property (state_reg == PMS_SETTLE ##1 state_reg == PMS_ACTIVE);
   c_direct_sub: cover property (state_reg == PMS_ACTIVE ##1 state_reg == PMS_SUBACTIVE);
   c_subsleep: cover property (state_reg == PMS_SUBSLEEP ##1 running);
   c_masked_sleep: cover property (state_reg == PMS_SLEEP && I_IRQ_PENDING && I_CPU_MASK);
endmodule

// >>> bench/pms_cpu_model.sv
`timescale 1ns/1ps
module pms_cpu_model (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // sequencer status
   input wire logic i_run,
   input wire logic i_wake,
   // bench commands
   input wire logic i_go_sleep,
   input wire logic i_irq,
   // to sequencer
   output logic o_sleep_exec,
   output logic o_irq_pending
);
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sleep_exec <= 1'b0;
         o_irq_pending <= 1'b0;
      end else begin
         // a halted cpu executes nothing, so sleep only issues while running
         o_sleep_exec <= i_go_sleep & i_run & ~o_sleep_exec;
         // request stays up until the sequencer accepts it, as a real source would
         o_irq_pending <= i_irq | (o_irq_pending & ~i_wake);
      end
   end
endmodule

// >>> bench/power_mode_sequencer_bench.sv
`timescale 1ns/1ps
`include "pms_defines.svh"
module power_mode_sequencer_bench;
   import pms_pkg::*;
   logic clk, rst_n, psel, pen, pwr, go, irq, mask, ext_n, rdy, err, sx, ip, run, wk, hiz, ls;
   logic pr, wh, wosc, dten, ien;
   logic [3:0] g;
   logic [11:0] pa;
   logic [31:0] pwd, prd, x;
   logic [31:0] q[$];
   logic [1:0] look;
   pms_state_t s;
   int bad_count, n_tests, i;
   localparam logic [21:0] TB [11] = '{{8'h00,PMS_SLEEP,PMS_ACTIVE}, {8'h08,PMS_SLEEP,PMS_SUBACTIVE},
      {8'h04,PMS_SUBSLEEP,PMS_ACTIVE}, {8'h0C,PMS_SUBSLEEP,PMS_SUBACTIVE}, {8'h01,PMS_ACTIVE,PMS_ACTIVE},
      {8'h01,PMS_ACTIVE,PMS_ACTIVE}, {8'h09,PMS_SUBACTIVE,PMS_SUBACTIVE}, {8'h09,PMS_SUBACTIVE,PMS_SUBACTIVE},
      {8'h0B,PMS_SUBACTIVE,PMS_SUBACTIVE}, {8'h03,PMS_ACTIVE,PMS_ACTIVE}, {8'h16,PMS_STANDBY,PMS_SETTLE}};
   pms_power_mode_sequencer u_pms_power_mode_sequencer (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy),
      .O_PSLVERR(err), .I_SLEEP_EXEC(sx), .I_IRQ_PENDING(ip), .I_IRQ_ENABLED(ien), .I_CPU_MASK(mask),
      .I_DT_IRQ_ENABLED(dten), .I_EXTERNAL_RESET_INPUT_N(ext_n), .I_WDT_INT_OSC(wosc),
      .O_SERIAL_UNIT_B_SLEEP(g[3]), .O_TIMER_B_UNIT_SLEEP(g[2]), .O_TIMER_Z_UNIT_SLEEP(g[1]),
      .O_PWM_UNIT_SLEEP(g[0]), .O_SUBSLEEP_PERIPH_RESET(pr), .O_WDT_HOLD(wh), .O_PORT_HIZ(hiz),
      .O_CPU_RUN(run), .O_LOW_SPEED(ls), .O_WAKE_IRQ(wk), .O_STATE(s));
   pms_cpu_model u_pms_cpu_model (.i_clk(clk), .i_rst_n(rst_n), .i_run(run), .i_wake(wk), .i_go_sleep(go),
      .i_irq(irq), .o_sleep_exec(sx), .o_irq_pending(ip));
   // ----
   // tasks
   // ----
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task test_done;
      if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
      // one idle edge so a following call never reassigns psel in this time step
      @(posedge clk);
   endtask
   // the monitor takes the note one edge after look is raised
   task pk(input logic [31:0] e, input logic [1:0] l);
      q.push_back(e);
      look <= l;
      @(posedge clk);
      look <= 2'd0;
   endtask
   // read data is taken by the monitor at the access edge where pready is high
   task rd(input logic [11:0] a, input logic [31:0] e);
      q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task st(input pms_state_t e, input logic p = 1'b0);
      pk(32'({p, ~wosc && (e == PMS_SUBACTIVE || e == PMS_SUBSLEEP || e == PMS_STANDBY || e == PMS_SETTLE),
         e == PMS_STANDBY || e == PMS_SETTLE, e == PMS_ACTIVE || e == PMS_SUBACTIVE,
         e == PMS_SUBACTIVE || e == PMS_SUBSLEEP, e}), 2'd2);
   endtask
   // w low pulses the sleep command, w high the interrupt command
   task pulse(input logic w);
      if (w) irq <= 1'b1;
      else go <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      go <= 1'b0;
      @(posedge clk);
   endtask
   // ----
   // monitor, clock, watchdog
   // ----
   always @(posedge clk) begin
      if (psel && pen) chk(32'(err), 32'(pa > 12'h008));
      if (psel && pen && rdy && !pwr) chk(prd, q.pop_front());
      if (look == 2'd2) chk(32'({pr, wh, hiz, run, ls, s}), q.pop_front());
      if (look == 2'd3) chk(32'(g), q.pop_front());
   end
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #40000;
      bad_count++;
      test_done;
   end
   // ----
   // main sequence
   // ----
   initial begin
      {psel, pen, pwr, go, irq, mask, rst_n} = '0;
      {pa, pwd, look, ext_n, x} = {44'h0, 2'h0, 1'b1, 32'd71007};
      {wosc, dten, ien} = 3'b011;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(`PMS_ADDR_GATE_B, 32'h0);
      rd(`PMS_ADDR_MODE, 32'h0);
      rd(`PMS_ADDR_STATE, 32'(PMS_ACTIVE));
      for (i = 0; i < 5; i++) begin
         x = (i == 4) ? 32'h0 : xs(x);
         apb(1'b1, `PMS_ADDR_GATE_B, x);
         apb(1'b1, 12'h00C, ~x); // refused write leaves the gate alone
         rd(`PMS_ADDR_GATE_B, x & 32'h93);
         rd(12'h00C, x & 32'h93);
         pk({28'h0, x[7], x[4], x[1], x[0]}, 2'd3);
      end
      for (i = 0; i < 11; i++) begin
         wosc <= i[0];
         apb(1'b1, `PMS_ADDR_MODE, 32'(TB[i][21:14]));
         pulse(1'b0);
         st(pms_state_t'(TB[i][13:7]), TB[i][16]);
         if (TB[i][13:7] != TB[i][6:0]) begin
            pulse(1'b1);
            st(pms_state_t'(TB[i][6:0]));
         end
      end
      repeat (500) @(posedge clk);
      st(PMS_SETTLE);
      repeat (20) @(posedge clk);
      st(PMS_ACTIVE);
      apb(1'b1, `PMS_ADDR_MODE, 32'h0); // software reprograms after the subsleep-select reset
      mask <= 1'b1;
      pulse(1'b0);
      pulse(1'b1);
      repeat (4) @(posedge clk);
      st(PMS_SLEEP);
      mask <= 1'b0;
      repeat (2) @(posedge clk);
      st(PMS_ACTIVE);
      pulse(1'b0);
      ext_n <= 1'b0;
      repeat (2) @(posedge clk);
      st(PMS_RESET);
      ext_n <= 1'b1;
      repeat (2) @(posedge clk);
      st(PMS_ACTIVE);
      dten <= 1'b0;
      apb(1'b1, `PMS_ADDR_MODE, 32'h01);
      pulse(1'b0);
      st(PMS_SLEEP);
      ien <= 1'b0;
      pulse(1'b1);
      repeat (2) @(posedge clk);
      st(PMS_SLEEP);
      ien <= 1'b1;
      repeat (2) @(posedge clk);
      st(PMS_ACTIVE);
      test_done;
   end
endmodule
